// ==== hdl/qdac_pkg.sv ====
// Shared constants and types of the quad converter update control
package qdac_pkg;

   // ****************************************************************
   // Widths and channel organisation
   // ****************************************************************
   localparam int QDAC_CHANNELS = 4;
   localparam int CODE_W = 14;
   localparam int GAIN_W = 8;
   localparam int ZERO_W = 9;
   localparam int LEVEL_W = 22;
   localparam int FRAME_W = 24;
   localparam int COUNT_W = 5;
   localparam int GROUP_B_FIRST = 2;

   // ****************************************************************
   // Serial frame layout
   // ****************************************************************
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int FR_RW_BIT = 23;
   localparam int FR_ADDR_HI = 22;
   localparam int FR_ADDR_LO = 19;
   localparam int FR_DATA_HI = 13;
   localparam int FR_DATA_LO = 0;

   // ****************************************************************
   // Register addresses carried in the frame
   // ****************************************************************
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_INPUT0 = 4'h4;
   localparam logic [3:0] ADDR_ZERO0 = 4'h8;
   localparam logic [3:0] ADDR_GAIN0 = 4'hc;

   // ****************************************************************
   // Command register fields
   // ****************************************************************
   localparam int CMD_RST_BIT = 7;
   localparam int CMD_LD_BIT = 6;
   localparam int CMD_GAIN_LO = 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [13:0] CODE_RST = 14'h0000;
   localparam logic [8:0] ZERO_RST = 9'h000;
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [3:0] GAIN4_RST = 4'hf;
   localparam logic [21:0] LEVEL_RST = 22'h000000;

   // ****************************************************************
   // Trim arithmetic: zero trim in 1/32 LSB, gain trim scale shifts
   // ****************************************************************
   localparam int ZERO_FRAC_BITS = 5;
   localparam int GAIN_SHIFT_BIP = 17;
   localparam int GAIN_SHIFT_UNI = 16;

   // Frame tracking in the system clock domain
   typedef enum logic [1:0] {
      FR_IDLE,
      FR_ACTIVE,
      FR_IGNORED
   } qdac_frame_t;

endpackage

// ==== hdl/qdac_spi_rx.sv ====
// Serial shift register running on the serial clock of the link
module qdac_spi_rx
   import qdac_pkg::*;
(
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   output logic [23:0] o_word,
   output logic [4:0] o_count
);

   // ****************************************************************
   // Frame marker
   // ****************************************************************

   // Cleared by select going high, set by the first clock edge of a frame
   logic in_frame;

   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         in_frame <= 1'b0;
      end else begin
         in_frame <= 1'b1;
      end
   end

   // ****************************************************************
   // Shift register and edge counter
   // ****************************************************************

   // Word and count stay frozen after select rises for the far side
   // MSB first shifting
   always_ff @(negedge i_sclk) begin
      if (!i_cs_n) begin
         o_word <= {o_word[22:0], i_sdi};
      end
   end

   always_ff @(negedge i_sclk) begin
      if (!i_cs_n) begin
         if (!in_frame) begin
            o_count <= 5'h01;
         end else if (o_count != FRAME_BITS) begin
            o_count <= 5'(o_count + 5'h01);
         end
      end
   end

endmodule // qdac_spi_rx

// ==== hdl/qdac_core.sv ====
// Update control core of the quad 14-bit converter
// Summary of operation
// - Channels 0,1 group A; 2,3 group B
// - Per-channel signed gain trim, -128..+127
// - Per-channel signed zero trim, -256..+255
// - Gain step quarter LSB unipolar, 1/16 LSB bipolar, zero 1/32
// - Both trim codes reset to zero
// - Bipolar group reads code as twos complement
// - Unipolar group reads code as straight binary
// - Readback uses the write format
// - Polarity pin high unipolar, low bipolar
// - Gain-select bit per channel, resets to one
// - Valid frame writes addressed input register
// - Load reloads only channels written since
// - Strobe low during frame updates latch too
// - Strobe high updates input register only
// - Strobe fall or load bit copies latches
// - Reset zeroes registers, latches and outputs, except gain select to ones
// - Serial inputs ignored while reset low
// - Latch and level outputs stay zero after reset release
// - Reset bit acts as reset, self-clears
// - Power-on loads reset code and defaults
// - 24-bit frame, MSB first, falling clock
// - Short frame dropped, last 24 bits kept
module qdac_core
   import qdac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   input wire logic i_latch_load_strobe_n,
   input wire logic i_polarity_select_a,
   input wire logic i_polarity_select_b,
   output logic [13:0] o_latch_code0,
   output logic [13:0] o_latch_code1,
   output logic [13:0] o_latch_code2,
   output logic [13:0] o_latch_code3,
   output logic [21:0] o_level0,
   output logic [21:0] o_level1,
   output logic [21:0] o_level2,
   output logic [21:0] o_level3,
   output logic [3:0] o_gain_x4,
   output logic [3:0] o_unipolar,
   output logic [23:0] o_rd_word,
   output logic o_rd_valid
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // One-hot channel hit for a bank of four consecutive addresses
   function automatic logic [3:0] qdac_hit(input logic [3:0] addr,
                                           input logic [3:0] base);
      logic [3:0] hit;
      hit = 4'h0;
      if (addr[3:2] == base[3:2]) begin
         hit[addr[1:0]] = 1'b1;
      end
      return hit;
   endfunction

   // Corrected level in 1/32 LSB from code, polarity and both trims
   function automatic logic signed [21:0] qdac_level(
      input logic [13:0] code,
      input logic uni,
      input logic [8:0] zero,
      input logic [7:0] gain);
      logic signed [21:0] base;
      logic signed [29:0] prod;
      logic signed [29:0] corr;
      base = 22'sh000000;
      prod = 30'sh00000000;
      corr = 30'sh00000000;
      if (uni) begin
         base = $signed({3'h0, code, 5'h00});
      end else begin
         base = $signed({{3{code[13]}}, code, 5'h00});
      end
      base = 22'(base + $signed({{13{zero[8]}}, zero}));
      prod = $signed({{8{base[21]}}, base}) *
             $signed({{22{gain[7]}}, gain});
      if (uni) begin
         corr = prod >>> GAIN_SHIFT_UNI;
      end else begin
         corr = prod >>> GAIN_SHIFT_BIP;
      end
      return 22'(base + $signed(corr[21:0]));
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic rst_meta;
   logic rst_sync;
   logic soft_rst;
   logic core_rst;
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;
   logic ld_meta;
   logic ld_sync;
   logic ld_prev;
   logic [1:0] pol_meta;
   logic [1:0] pol_sync;
   logic [23:0] rx_word;
   logic [4:0] rx_count;
   qdac_frame_t frame_state;
   logic cs_rise;
   logic cs_fall;
   logic ld_fall;
   logic capture;
   logic wr;
   logic rd;
   logic [3:0] addr;
   logic [13:0] data;
   logic [3:0] in_wr;
   logic [3:0] zero_wr;
   logic [3:0] gain_wr;
   logic cmd_wr;
   logic ld_cmd;
   logic rst_cmd;
   logic load_event;
   logic direct;
   logic [3:0] pending;
   logic [3:0] uni;
   logic [3:0] gain4;
   logic [13:0] rd_data;
   logic [13:0] in_reg [4];
   logic [13:0] latch [4];
   logic [8:0] zero_trim [4];
   logic [7:0] gain_trim [4];
   logic [21:0] level [4];

   // ****************************************************************
   // Serial receiver on the link clock
   // ****************************************************************
   qdac_spi_rx u_rx (
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_sdi(i_sdi),
      .o_word(rx_word),
      .o_count(rx_count)
   );

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   always_ff @(posedge i_clk) begin
      rst_meta <= i_rst_n;
      rst_sync <= rst_meta;
   end

   // Software reset joins the hardware reset
   assign core_rst = !rst_sync || soft_rst;

   // Select and strobe pins, idle levels under reset
   // Select and strobe synchroniser
   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         ld_meta <= 1'b1;
         ld_sync <= 1'b1;
         ld_prev <= 1'b1;
      end else begin
         cs_meta <= i_cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         ld_meta <= i_latch_load_strobe_n;
         ld_sync <= ld_meta;
         ld_prev <= ld_sync;
      end
   end

   // Polarity pins follow freely, also during reset
   always_ff @(posedge i_clk) begin
      pol_meta <= {i_polarity_select_b, i_polarity_select_a};
      pol_sync <= pol_meta;
   end

   // Edge detectors read only the settled stages
   assign cs_rise = cs_sync && !cs_prev;
   assign cs_fall = !cs_sync && cs_prev;
   // Strobe fall is one load event
   assign ld_fall = !ld_sync && ld_prev;

   // ****************************************************************
   // Frame tracking
   // ****************************************************************

   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         frame_state <= FR_IGNORED;
      end else begin
         case (frame_state)
            FR_IDLE: begin
               if (cs_fall) begin
                  frame_state <= FR_ACTIVE;
               end
            end
            FR_ACTIVE: begin
               if (cs_rise) begin
                  frame_state <= FR_IDLE;
               end
            end
            FR_IGNORED: begin
               if (cs_sync) begin
                  frame_state <= FR_IDLE;
               end
            end
            default: begin
               frame_state <= FR_IGNORED;
            end
         endcase
      end
   end

   assign capture = (frame_state == FR_ACTIVE) && cs_rise &&
                    (rx_count == FRAME_BITS);
   assign wr = capture && !rx_word[FR_RW_BIT];
   assign rd = capture && rx_word[FR_RW_BIT];
   assign addr = rx_word[FR_ADDR_HI:FR_ADDR_LO];
   assign data = rx_word[FR_DATA_HI:FR_DATA_LO];

   // ****************************************************************
   // Write decode and command bits
   // ****************************************************************
   assign in_wr = wr ? qdac_hit(addr, ADDR_INPUT0) : 4'h0;
   assign zero_wr = wr ? qdac_hit(addr, ADDR_ZERO0) : 4'h0;
   assign gain_wr = wr ? qdac_hit(addr, ADDR_GAIN0) : 4'h0;
   assign cmd_wr = wr && (addr == ADDR_CMD);
   assign rst_cmd = cmd_wr && data[CMD_RST_BIT];
   // Load bit acts once, never stored
   assign ld_cmd = cmd_wr && data[CMD_LD_BIT] && !data[CMD_RST_BIT];
   assign load_event = ld_fall || ld_cmd;
   assign direct = !ld_sync;

   // Reset bit pulses once, then clears
   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= rst_cmd;
      end
   end

   // Gain-select bits reset to gain four
   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         gain4 <= GAIN4_RST;
      end else if (cmd_wr && !data[CMD_RST_BIT]) begin
         gain4 <= data[CMD_GAIN_LO +: 4];
      end
   end

   // ****************************************************************
   // Double-buffered channel registers
   // ****************************************************************

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         if (core_rst) begin
            in_reg[i] <= CODE_RST;
         end else if (in_wr[i]) begin
            in_reg[i] <= data;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         if (core_rst) begin
            pending[i] <= 1'b0;
         end else if (in_wr[i]) begin
            pending[i] <= !direct;
         end else if (load_event) begin
            pending[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         if (core_rst) begin
            latch[i] <= CODE_RST;
         end else if (in_wr[i] && direct) begin
            latch[i] <= data;
         end else if (load_event && pending[i]) begin
            latch[i] <= in_reg[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         if (core_rst) begin
            zero_trim[i] <= ZERO_RST;
            gain_trim[i] <= GAIN_RST;
         end else begin
            if (zero_wr[i]) begin
               zero_trim[i] <= data[8:0];
            end
            if (gain_wr[i]) begin
               gain_trim[i] <= data[7:0];
            end
         end
      end
   end

   // ****************************************************************
   // Output levels
   // ****************************************************************

   always_comb begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         uni[i] = (i < GROUP_B_FIRST) ? pol_sync[0] : pol_sync[1];
      end
   end

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < QDAC_CHANNELS; i++) begin
         if (core_rst) begin
            level[i] <= LEVEL_RST;
         end else begin
            level[i] <= qdac_level(latch[i], uni[i], zero_trim[i],
                                   gain_trim[i]);
         end
      end
   end

   // Mode outputs registered with the rest
   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         o_gain_x4 <= GAIN4_RST;
         o_unipolar <= 4'h0;
      end else begin
         o_gain_x4 <= gain4;
         o_unipolar <= uni;
      end
   end

   assign o_latch_code0 = latch[0];
   assign o_latch_code1 = latch[1];
   assign o_latch_code2 = latch[2];
   assign o_latch_code3 = latch[3];
   assign o_level0 = level[0];
   assign o_level1 = level[1];
   assign o_level2 = level[2];
   assign o_level3 = level[3];

   // ****************************************************************
   // Readback
   // ****************************************************************

   always_comb begin
      rd_data = 14'h0000;
      if (addr == ADDR_CMD) begin
         rd_data[CMD_GAIN_LO +: 4] = gain4;
      end else if (addr[3:2] == ADDR_INPUT0[3:2]) begin
         rd_data = in_reg[addr[1:0]];
      end else if (addr[3:2] == ADDR_ZERO0[3:2]) begin
         rd_data[8:0] = zero_trim[addr[1:0]];
      end else if (addr[3:2] == ADDR_GAIN0[3:2]) begin
         rd_data[7:0] = gain_trim[addr[1:0]];
      end
   end

   always_ff @(posedge i_clk) begin
      if (core_rst) begin
         o_rd_word <= 24'h000000;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= rd;
         if (rd) begin
            o_rd_word <= {1'b1, addr, 5'h00, rd_data};
         end
      end
   end

endmodule // qdac_core

// ==== tb/qdac_core_sva.sv ====
// Assertion checker for the quad converter update control
module qdac_core_sva
   import qdac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic i_latch_load_strobe_n,
   input wire logic i_polarity_select_a,
   input wire logic i_polarity_select_b,
   input wire logic [13:0] o_latch_code0,
   input wire logic [13:0] o_latch_code3,
   input wire logic [21:0] o_level0,
   input wire logic [21:0] o_level3,
   input wire logic [3:0] o_gain_x4,
   input wire logic [3:0] o_unipolar,
   input wire logic [23:0] o_rd_word,
   input wire logic o_rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************************
   // Helper counters
   // ***************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   logic [3:0] quiet;
   logic [2:0] age;
   logic [3:0] cs_hi;
   // Cycles with no frame, strobe edge or polarity change
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_cs_n || !$stable(i_latch_load_strobe_n) ||
          !$stable({i_polarity_select_a, i_polarity_select_b})) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
         quiet <= quiet + 4'h1;
      end
   end
   // Cycles since reset release, saturating
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   // Cycles since chip select went high
   always_ff @(posedge i_clk) begin
      if (!i_cs_n) begin
         cs_hi <= 4'h0;
      end else if (cs_hi != 4'hf) begin
         cs_hi <= cs_hi + 4'h1;
      end
   end
   // ***************************************************
   // Assertions
   // ***************************************************
   chk_latch_rst: assert property (!i_rst_n [*5] |->
      o_latch_code0 == 14'h0000 && o_level3 == 22'h000000)
      else $error("latch not cleared in reset");
   chk_gain_rst: assert property (!i_rst_n [*5] |->
      o_gain_x4 == 4'hf && o_unipolar == 4'h0)
      else $error("gain select not set in reset");
   chk_latch_hold: assert property (disable iff (!i_rst_n)
      quiet > 4'h8 |-> $stable(o_latch_code0) && $stable(o_level0)
      && $stable(o_latch_code3) && $stable(o_level3))
      else $error("latch moved without cause");
   chk_gain_hold: assert property (disable iff (!i_rst_n)
      quiet > 4'h8 |-> $stable(o_gain_x4))
      else $error("gain select moved without write");
   chk_uni_a: assert property (disable iff (!i_rst_n)
      (age == 3'h7 && $stable(i_polarity_select_a)) [*4] |->
      o_unipolar[1:0] == {2{i_polarity_select_a}})
      else $error("group a mode wrong");
   chk_uni_b: assert property (disable iff (!i_rst_n)
      (age == 3'h7 && $stable(i_polarity_select_b)) [*4] |->
      o_unipolar[3:2] == {2{i_polarity_select_b}})
      else $error("group b mode wrong");
   chk_rd_pulse: assert property (disable iff (!i_rst_n)
      o_rd_valid |=> !o_rd_valid)
      else $error("read valid longer than one cycle");
   chk_rd_form: assert property (disable iff (!i_rst_n)
      o_rd_valid |-> o_rd_word[23] && o_rd_word[18:14] == 5'h00)
      else $error("read word layout wrong");
   chk_rd_time: assert property (disable iff (!i_rst_n)
      o_rd_valid |-> i_cs_n && cs_hi inside {[4'h1:4'h6]})
      else $error("read answer not after frame end");
   cov_read: cover property (disable iff (!i_rst_n) o_rd_valid);
   cov_load: cover property (disable iff (!i_rst_n)
      $fell(i_latch_load_strobe_n));
   cov_uni: cover property (disable iff (!i_rst_n) o_unipolar == 4'hf);
endmodule // qdac_core_sva

bind qdac_core qdac_core_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_cs_n(i_cs_n), .i_latch_load_strobe_n(i_latch_load_strobe_n),
   .i_polarity_select_a(i_polarity_select_a),
   .i_polarity_select_b(i_polarity_select_b),
   .o_latch_code0(o_latch_code0), .o_latch_code3(o_latch_code3),
   .o_level0(o_level0), .o_level3(o_level3), .o_gain_x4(o_gain_x4),
   .o_unipolar(o_unipolar), .o_rd_word(o_rd_word),
   .o_rd_valid(o_rd_valid));

// ==== tb/qdac_host_model.sv ====
// Host side serial master model for the converter link
module qdac_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clock idles high so the first edge in a frame falls
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b0;
      o_sdi = 1'b0;
      // A real select rise clears the frame marker before any frame
      #1 o_cs_n = 1'b1;
   end
   task automatic send(input logic [23:0] w, input int n);
      #70;
      o_cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         o_sdi <= (i < 24) ? w[i] : 1'b1;
         #24 o_sclk <= 1'b0;
         #24 o_sclk <= 1'b1;
      end
      o_cs_n <= 1'b1;
      o_sdi <= ~o_sdi; // Line no longer holds the last bit
   endtask
endmodule // qdac_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the quad converter update control
module tb
   import qdac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst_n, i_latch_load_strobe_n;
   logic i_polarity_select_a, i_polarity_select_b, sclk, cs_n, sdi;
   logic [13:0] o_latch_code0, o_latch_code1, o_latch_code2, o_latch_code3;
   logic [21:0] o_level0, o_level1, o_level2, o_level3;
   logic [3:0] o_gain_x4, o_unipolar;
   logic [23:0] o_rd_word;
   logic o_rd_valid;
   int error_cnt = 0;
   int compares = 0;
   qdac_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
   qdac_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_sdi(sdi),
      .i_latch_load_strobe_n(i_latch_load_strobe_n),
      .i_polarity_select_a(i_polarity_select_a),
      .i_polarity_select_b(i_polarity_select_b),
      .o_latch_code0(o_latch_code0), .o_latch_code1(o_latch_code1),
      .o_latch_code2(o_latch_code2), .o_latch_code3(o_latch_code3),
      .o_level0(o_level0), .o_level1(o_level1), .o_level2(o_level2),
      .o_level3(o_level3), .o_gain_x4(o_gain_x4),
      .o_unipolar(o_unipolar), .o_rd_word(o_rd_word),
      .o_rd_valid(o_rd_valid));
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic end_sim();
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   function automatic logic [23:0] fw(input logic rw,
                                      input logic [3:0] a,
                                      input logic [13:0] d);
      return {rw, a, 5'h00, d};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [13:0] d);
      host.send(fw(1'b0, a, d), 24);
      wait_clk(8);
   endtask
   task automatic rd(input logic [3:0] a, input logic [23:0] exp);
      int k;
      k = 0;
      host.send(fw(1'b1, a, 14'h0000), 24);
      while (o_rd_valid !== 1'b1 && k < 20) begin
         @(negedge i_clk);
         k++;
      end
      check("rd_valid", {23'h0, o_rd_valid}, 24'h1); // Pulse
      check("rd_word", o_rd_word, exp); // Layout
   endtask
   task automatic strobe(input logic v);
      @(posedge i_clk);
      i_latch_load_strobe_n <= v;
      wait_clk(6);
   endtask
   task automatic pol(input logic a, b);
      @(posedge i_clk);
      i_polarity_select_a <= a;
      i_polarity_select_b <= b;
      wait_clk(6);
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      check("latch0", {10'h0, o_latch_code0}, 24'h0); // Cleared
      check("latch3", {10'h0, o_latch_code3}, 24'h0); // Cleared
      check("level0", {2'h0, o_level0}, 24'h0); // Zero out
      check("gain", {20'h0, o_gain_x4}, 24'hf); // Default x4
      check("uni", {20'h0, o_unipolar}, 24'h0); // Bipolar
   endtask
   task automatic t_direct();
      strobe(1'b0);
      wr(ADDR_INPUT0, 14'h2000);
      check("latch0", {10'h0, o_latch_code0}, 24'h2000); // Direct
      check("level0", {2'h0, o_level0}, 24'h3c0000); // Signed
      strobe(1'b1);
   endtask
   task automatic t_group();
      wr(ADDR_INPUT0 + 4'h1, 14'h0123);
      wr(ADDR_INPUT0 + 4'h2, 14'h0456);
      check("latch1", {10'h0, o_latch_code1}, 24'h0); // Held
      check("latch2", {10'h0, o_latch_code2}, 24'h0); // Held
      strobe(1'b0);
      check("latch1", {10'h0, o_latch_code1}, 24'h0123); // Load
      check("latch2", {10'h0, o_latch_code2}, 24'h0456); // Load
      check("latch0", {10'h0, o_latch_code0}, 24'h2000); // Kept
      check("latch3", {10'h0, o_latch_code3}, 24'h0); // Kept
      strobe(1'b1);
   endtask
   task automatic t_ldbit();
      wr(ADDR_INPUT0 + 4'h3, 14'h0777);
      check("latch3", {10'h0, o_latch_code3}, 24'h0); // Held
      wr(ADDR_CMD, 14'h0040);
      check("latch3", {10'h0, o_latch_code3}, 24'h0777); // Bit
      check("level3", {2'h0, o_level3}, 24'h00eee0); // Level
      check("gain", {20'h0, o_gain_x4}, 24'h0); // Cleared x2
      rd(ADDR_CMD, fw(1'b1, ADDR_CMD, 14'h0000)); // One-shot
   endtask
   task automatic t_frames();
      strobe(1'b0);
      host.send(fw(1'b0, ADDR_INPUT0, 14'h0001), 23);
      wait_clk(8);
      check("latch0", {10'h0, o_latch_code0}, 24'h2000); // Short
      host.send(fw(1'b0, ADDR_INPUT0, 14'h0011), 26);
      wait_clk(8);
      check("latch0", {10'h0, o_latch_code0}, 24'h0011); // Long
   endtask
   task automatic t_polar();
      pol(1'b1, 1'b0);
      check("uni", {20'h0, o_unipolar}, 24'h3); // Group a
      wr(ADDR_INPUT0, 14'h3fff);
      wr(ADDR_INPUT0 + 4'h2, 14'h3fff);
      check("level0", {2'h0, o_level0}, 24'h07ffe0); // Binary
      check("level2", {2'h0, o_level2}, 24'h3fffe0); // Signed
      pol(1'b1, 1'b1);
      check("uni", {20'h0, o_unipolar}, 24'hf); // Group b
      pol(1'b0, 1'b0);
      check("uni", {20'h0, o_unipolar}, 24'h0); // Low pins
   endtask
   task automatic t_trim();
      wr(ADDR_ZERO0 + 4'h1, 14'h01ff);
      wr(ADDR_INPUT0 + 4'h1, 14'h0010);
      check("level1", {2'h0, o_level1}, 24'h0001ff); // Trim
      rd(ADDR_ZERO0 + 4'h1, fw(1'b1, ADDR_ZERO0 + 4'h1, 14'h01ff));
      wr(ADDR_GAIN0 + 4'h1, 14'h0080);
      check("level1", {2'h0, o_level1}, 24'h0001fe); // Gain
      rd(ADDR_GAIN0 + 4'h1, fw(1'b1, ADDR_GAIN0 + 4'h1, 14'h0080));
   endtask
   task automatic t_hwrst();
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      wait_clk(5);
      wr(ADDR_INPUT0, 14'h0055);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      wait_clk(6);
      check("latch0", {10'h0, o_latch_code0}, 24'h0); // Ignored
      check("level1", {2'h0, o_level1}, 24'h0); // Zero out
      rd(ADDR_ZERO0 + 4'h1, fw(1'b1, ADDR_ZERO0 + 4'h1, 14'h0));
   endtask
   task automatic t_swrst();
      wr(ADDR_INPUT0 + 4'h2, 14'h0100);
      check("latch2", {10'h0, o_latch_code2}, 24'h0100); // Direct
      wr(ADDR_CMD, 14'h0080);
      check("latch2", {10'h0, o_latch_code2}, 24'h0); // Soft
      check("gain", {20'h0, o_gain_x4}, 24'hf); // Default x4
      rd(ADDR_CMD, fw(1'b1, ADDR_CMD, 14'h003c)); // Self-clear
   endtask
   // ***************************************************
   // Clock, watchdog and main sequence
   // ***************************************************
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #300us;
      error_cnt++;
      end_sim();
   end
   initial begin
      i_rst_n = 1'b0;
      i_latch_load_strobe_n = 1'b1;
      i_polarity_select_a = 1'b0;
      i_polarity_select_b = 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wait_clk(6);
      t_reset();
      t_direct();
      t_group();
      t_ldbit();
      t_frames();
      t_polar();
      t_trim();
      t_hwrst();
      t_swrst();
      end_sim();
   end
endmodule // tb
